// [hdl/reset_phase_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module reset_phase_timer (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [12:0] load_value,
  output logic expired
);

  logic [12:0] count_r;

  // ---------------------------------------------------------------
  // Down counter; a load of N-1 lets a phase last N cycles.
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_r <= 13'h0000;
    end else if (start) begin
      count_r <= load_value;
    end else if (count_r != 13'h0000) begin
      count_r <= count_r - 13'h0001;
    end
  end

  assign expired = (count_r == 13'h0000);

endmodule
`default_nettype wire

// [hdl/reset_sequence_manager.sv]
// Functional notes
// - External pin, low supply and watchdog each start a sequence; pin low during delay.
// - Phases run in order: cause delay, 4096-cycle wait, vector fetch.
// - Vector fetch lasts exactly two cycles right after the wait.
// - Start address comes from the vector pair at the top of memory.
// - Reset pin is input and open-drain output; device only drives low.
// - External pulse is caught without the clock in the run state, even when halted.
// - While the supply is low the reset pin is held low from the cycle after detection, except during the two vector fetch cycles and the run cycle after them.
// - Supply detector uses rising threshold powering up, falling threshold powering down.
// - Watchdog underflow drives the pin low for a fixed pulse width.
// - Main oscillator stays enabled throughout reset.
// - Supply detector exists only when selected at build time.
// - Power-on and voltage-drop sequences are told apart.
`timescale 1ns/100ps
`default_nettype none
module reset_sequence_manager #(
  parameter bit LOW_SUPPLY_DETECTOR_PRESENT = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic rst_pin_in_n,
  output logic rst_pin_out_r,
  output logic rst_pin_oe_n_r,
  input wire logic supply_above_rising_threshold,
  input wire logic supply_above_falling_threshold,
  input wire logic watchdog_underflow,
  output logic internal_reset_r,
  output logic vector_fetch_r,
  output logic [15:0] fetch_addr_r,
  output logic osc_enable_r,
  output reset_sequencer_pkg::reset_cause_t reset_cause_r
);

  reset_sequencer_pkg::seq_state_t state_r, state_nxt;
  reset_sequencer_pkg::reset_cause_t cause_nxt;
  logic supply_low_r, supply_low_nxt, powered_once_r;
  logic ext_seen_r, ext_req, timer_start, timer_expired;
  logic [12:0] timer_load, stab_cnt_r, delay_cnt_r;

  // ---------------------------------------------------------------
  // Low supply detector with hysteresis
  // ---------------------------------------------------------------
  always_comb begin
    if (!LOW_SUPPLY_DETECTOR_PRESENT) begin
      supply_low_nxt = 1'b0;
    end else if (supply_low_r) begin
      supply_low_nxt = !supply_above_rising_threshold;
    end else begin
      supply_low_nxt = !supply_above_falling_threshold;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      supply_low_r <= LOW_SUPPLY_DETECTOR_PRESENT;
    end else begin
      supply_low_r <= supply_low_nxt;
    end
  end

  // Marks that the supply has been good once, to split power-on from drop.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      powered_once_r <= 1'b0;
    end else if (!supply_low_r) begin
      powered_once_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // External pin capture
  // ---------------------------------------------------------------
  // clockless capture
  always_ff @(posedge ref_clk or negedge rst_pin_in_n) begin
    if (!rst_pin_in_n) begin
      ext_seen_r <= 1'b1;
    end else if (srst || state_r != reset_sequencer_pkg::ST_RUN) begin
      ext_seen_r <= 1'b0;
    end
  end

  // The pin is ignored while this block drives it, in the first wait cycle and during vector fetch.
  always_comb begin
    ext_req = 1'b0;
    if (state_r == reset_sequencer_pkg::ST_RUN) begin
      ext_req = ext_seen_r || !rst_pin_in_n;
    end else if (state_r == reset_sequencer_pkg::ST_STAB && stab_cnt_r != 13'h0000) begin
      ext_req = !rst_pin_in_n;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cause_nxt = reset_cause_r;
    timer_start = 1'b0;
    timer_load = 13'h0000;
    unique case (state_r)
      reset_sequencer_pkg::ST_RUN: begin
        if (supply_low_r) begin
          state_nxt = reset_sequencer_pkg::ST_DELAY;
          cause_nxt = reset_sequencer_pkg::CAUSE_VOLTAGE_DROP;
        end else if (ext_req) begin
          state_nxt = reset_sequencer_pkg::ST_DELAY;
          cause_nxt = reset_sequencer_pkg::CAUSE_EXTERNAL;
        end else if (watchdog_underflow) begin
          state_nxt = reset_sequencer_pkg::ST_DELAY;
          cause_nxt = reset_sequencer_pkg::CAUSE_WATCHDOG;
        end
      end
      reset_sequencer_pkg::ST_DELAY: begin
        if (!supply_low_r && timer_expired) begin
          state_nxt = reset_sequencer_pkg::ST_STAB;
        end
      end
      reset_sequencer_pkg::ST_STAB: begin
        if (supply_low_r || ext_req) begin
          state_nxt = reset_sequencer_pkg::ST_DELAY;
          cause_nxt = supply_low_r ? reset_sequencer_pkg::CAUSE_VOLTAGE_DROP
                                   : reset_sequencer_pkg::CAUSE_EXTERNAL;
        end else if (timer_expired) begin
          state_nxt = reset_sequencer_pkg::ST_FETCH;
        end
      end
      reset_sequencer_pkg::ST_FETCH: begin
        if (timer_expired) begin
          state_nxt = reset_sequencer_pkg::ST_RUN;
        end
      end
    endcase
    if (cause_nxt == reset_sequencer_pkg::CAUSE_VOLTAGE_DROP && !powered_once_r) begin
      cause_nxt = reset_sequencer_pkg::CAUSE_POWER_ON;
    end
    if (state_nxt != state_r) begin
      timer_start = 1'b1;
      unique case (state_nxt)
        reset_sequencer_pkg::ST_RUN: timer_load = 13'h0000;
        reset_sequencer_pkg::ST_DELAY: begin
          timer_load = (cause_nxt == reset_sequencer_pkg::CAUSE_WATCHDOG)
                       ? reset_sequencer_pkg::WATCHDOG_PULSE_CYCLES - 13'h0001
                       : reset_sequencer_pkg::EXTERNAL_DELAY_CYCLES - 13'h0001;
        end
        reset_sequencer_pkg::ST_STAB: timer_load = reset_sequencer_pkg::STAB_CYCLES - 13'h0001;
        reset_sequencer_pkg::ST_FETCH: timer_load = reset_sequencer_pkg::FETCH_CYCLES - 13'h0001;
      endcase
    end else if (state_r == reset_sequencer_pkg::ST_DELAY && (supply_low_r || !powered_once_r)) begin
      // The delay is counted from the first cycle with a good supply.
      timer_start = 1'b1;
      timer_load = reset_sequencer_pkg::EXTERNAL_DELAY_CYCLES - 13'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= reset_sequencer_pkg::ST_DELAY;
      reset_cause_r <= reset_sequencer_pkg::CAUSE_POWER_ON;
    end else begin
      state_r <= state_nxt;
      reset_cause_r <= cause_nxt;
    end
  end

  reset_phase_timer phase_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(timer_start),
    .load_value(timer_load),
    .expired(timer_expired)
  );

  // ---------------------------------------------------------------
  // Outputs; pin enable, reset and fetch flag taken from the next state
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_pin_out_r <= 1'b0;
      rst_pin_oe_n_r <= 1'b0;
      internal_reset_r <= 1'b1;
      osc_enable_r <= 1'b1;
    end else begin
      rst_pin_out_r <= 1'b0;
      rst_pin_oe_n_r <= (state_nxt != reset_sequencer_pkg::ST_DELAY);
      internal_reset_r <= (state_nxt != reset_sequencer_pkg::ST_RUN);
      osc_enable_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vector_fetch_r <= 1'b0;
      fetch_addr_r <= reset_sequencer_pkg::VECTOR_HIGH_ADDR;
    end else begin
      vector_fetch_r <= (state_nxt == reset_sequencer_pkg::ST_FETCH);
      if (state_nxt == reset_sequencer_pkg::ST_FETCH && state_r == reset_sequencer_pkg::ST_FETCH) begin
        fetch_addr_r <= reset_sequencer_pkg::VECTOR_LOW_ADDR;
      end else begin
        fetch_addr_r <= reset_sequencer_pkg::VECTOR_HIGH_ADDR;
      end
    end
  end

  // ---------------------------------------------------------------
  // Phase length counters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || state_nxt != state_r) begin
      stab_cnt_r <= 13'h0000;
      delay_cnt_r <= 13'h0000;
    end else begin
      stab_cnt_r <= (state_r == reset_sequencer_pkg::ST_STAB) ? stab_cnt_r + 13'h0001 : 13'h0000;
      delay_cnt_r <= (state_r == reset_sequencer_pkg::ST_DELAY) ? delay_cnt_r + 13'h0001 : 13'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_delay_pin_low;
    @(posedge ref_clk) disable iff (srst)
    state_r == reset_sequencer_pkg::ST_DELAY |-> !rst_pin_oe_n_r && internal_reset_r;
  endproperty
  a_delay_pin_low: assert property (p_delay_pin_low) else $error("pin not low in delay");
  property p_wait_length;
    @(posedge ref_clk) disable iff (srst)
    (state_r == reset_sequencer_pkg::ST_FETCH && $past(state_r) == reset_sequencer_pkg::ST_STAB)
    |-> $past(stab_cnt_r) == 13'h0fff;
  endproperty
  a_wait_length: assert property (p_wait_length) else $error("wait not 4096 cycles");
  property p_fetch_two;
    @(posedge ref_clk) disable iff (srst)
    (state_r == reset_sequencer_pkg::ST_FETCH && $past(state_r) != reset_sequencer_pkg::ST_FETCH)
    |-> $past(state_r) == reset_sequencer_pkg::ST_STAB ##1 vector_fetch_r ##1
        (!vector_fetch_r && !internal_reset_r);
  endproperty
  a_fetch_two: assert property (p_fetch_two) else $error("fetch not two cycles");
  property p_vector_pair;
    @(posedge ref_clk) disable iff (srst)
    $rose(vector_fetch_r) |-> fetch_addr_r == 16'hfffe ##1 fetch_addr_r == 16'hffff;
  endproperty
  a_vector_pair: assert property (p_vector_pair) else $error("wrong vector address");
  property p_drive_low_only;
    @(posedge ref_clk) disable iff (srst)
    !rst_pin_oe_n_r |-> rst_pin_out_r == 1'b0;
  endproperty
  a_drive_low_only: assert property (p_drive_low_only) else $error("pin driven high");
  property p_ext_enters;
    @(posedge ref_clk) disable iff (srst)
    (state_r == reset_sequencer_pkg::ST_RUN && !rst_pin_in_n) |=> state_r == reset_sequencer_pkg::ST_DELAY;
  endproperty
  a_ext_enters: assert property (p_ext_enters) else $error("external reset missed");
  property p_low_supply_pin;
    @(posedge ref_clk) disable iff (srst)
    supply_low_r [*3] |-> !rst_pin_oe_n_r;
  endproperty
  a_low_supply_pin: assert property (p_low_supply_pin) else $error("pin free while supply low");
  property p_hysteresis;
    @(posedge ref_clk) disable iff (srst)
    (!supply_low_r && supply_above_falling_threshold) |=> !supply_low_r;
  endproperty
  a_hysteresis: assert property (p_hysteresis) else $error("hysteresis broken");
  property p_watchdog_width;
    @(posedge ref_clk) disable iff (srst)
    (state_r == reset_sequencer_pkg::ST_STAB && $past(state_r) == reset_sequencer_pkg::ST_DELAY &&
     reset_cause_r == reset_sequencer_pkg::CAUSE_WATCHDOG)
    |-> $past(delay_cnt_r) == reset_sequencer_pkg::WATCHDOG_PULSE_CYCLES - 13'h0001;
  endproperty
  a_watchdog_width: assert property (p_watchdog_width) else $error("watchdog pulse width wrong");
  property p_osc_running;
    @(posedge ref_clk) disable iff (srst)
    internal_reset_r |-> osc_enable_r;
  endproperty
  a_osc_running: assert property (p_osc_running) else $error("oscillator stopped in reset");
  property p_cause_split;
    @(posedge ref_clk) disable iff (srst)
    (reset_cause_r == reset_sequencer_pkg::CAUSE_VOLTAGE_DROP) |-> powered_once_r;
  endproperty
  a_cause_split: assert property (p_cause_split) else $error("drop reported before power-on");

endmodule
`default_nettype wire

// [hdl/reset_sequencer_pkg.sv]
package reset_sequencer_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TIMER_W = 13;
  localparam logic [12:0] STAB_CYCLES = 13'h1000;
  localparam logic [12:0] FETCH_CYCLES = 13'h0002;
  // Pulse widths with plain default values.
  localparam int unsigned WATCHDOG_RESET_PULSE_WIDTH_NS = 1000;
  localparam int unsigned EXTERNAL_RESET_DELAY_NS = 1000;
  localparam logic [12:0] WATCHDOG_PULSE_CYCLES =
    13'((WATCHDOG_RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [12:0] EXTERNAL_DELAY_CYCLES =
    13'((EXTERNAL_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Reset vector
  // ---------------------------------------------------------------
  localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hfffe;
  localparam logic [15:0] VECTOR_LOW_ADDR = 16'hffff;

  // ---------------------------------------------------------------
  // States and causes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DELAY = 2'b01,
    ST_STAB = 2'b10,
    ST_FETCH = 2'b11
  } seq_state_t;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_EXTERNAL = 3'b001,
    CAUSE_WATCHDOG = 3'b010,
    CAUSE_POWER_ON = 3'b011,
    CAUSE_VOLTAGE_DROP = 3'b100
  } reset_cause_t;

endpackage

// [verification/reset_line_partner.sv]
`timescale 1ns/100ps
`default_nettype none
module reset_line_partner (
  input wire logic dev_oe_n,
  input wire logic dev_out,
  input wire logic pull_low,
  output logic pin_level_n
);
  // ---------------------------------------------------------------
  // Shared reset line
  // ---------------------------------------------------------------
  // Weak pull-up wins only when no party pulls the line low.
  // open drain line
  always_comb begin
    pin_level_n = ((!dev_oe_n && !dev_out) || pull_low) ? 1'b0 : 1'b1;
  end
endmodule
`default_nettype wire

// [verification/tb_reset_sequence_manager.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_reset_sequence_manager;
  typedef struct {int kind; reset_sequencer_pkg::reset_cause_t cause; int dmin; int dmax; bit poke;} row_t;
  logic ref_clk, srst, pin_n, oe_n, pin_out, rise_ok, fall_ok, wdog, pull_low;
  logic ir, vf, osc, nolvd_ir;
  logic [15:0] addr;
  reset_sequencer_pkg::reset_cause_t cause;
  int err_total = 0;
  int samples_checked = 0;
  row_t rows [4];

  reset_sequence_manager u_dut (
    .ref_clk(ref_clk), .srst(srst), .rst_pin_in_n(pin_n), .rst_pin_out_r(pin_out),
    .rst_pin_oe_n_r(oe_n), .supply_above_rising_threshold(rise_ok),
    .supply_above_falling_threshold(fall_ok), .watchdog_underflow(wdog),
    .internal_reset_r(ir), .vector_fetch_r(vf), .fetch_addr_r(addr),
    .osc_enable_r(osc), .reset_cause_r(cause)
  );

  reset_sequence_manager #(.LOW_SUPPLY_DETECTOR_PRESENT(1'b0)) u_dut_nolvd (
    .ref_clk(ref_clk), .srst(srst), .rst_pin_in_n(1'b1), .rst_pin_out_r(),
    .rst_pin_oe_n_r(), .supply_above_rising_threshold(1'b0),
    .supply_above_falling_threshold(1'b0), .watchdog_underflow(1'b0),
    .internal_reset_r(nolvd_ir), .vector_fetch_r(), .fetch_addr_r(),
    .osc_enable_r(), .reset_cause_r()
  );

  reset_line_partner u_line (
    .dev_oe_n(oe_n), .dev_out(pin_out), .pull_low(pull_low), .pin_level_n(pin_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Triggers the cause chosen by r.kind (none for kind 3), then times every phase of the sequence.
  task automatic measure(input row_t r);
    int n;
    case (r.kind)
      0: begin
        wdog = 1'b1;
        @(negedge ref_clk);
        wdog = 1'b0;
      end
      1: begin
        // A pulse far shorter than a clock period must still be caught.
        pull_low = 1'b1;
        #5;
        pull_low = 1'b0;
      end
      2: begin
        rise_ok = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(oe_n === 1'b1, "reset below rising threshold while running");
        fall_ok = 1'b0;
        repeat (20) @(negedge ref_clk);
        chk(oe_n === 1'b0, "pin released while supply low");
        rise_ok = 1'b1;
        fall_ok = 1'b1;
      end
      default: ;
    endcase
    n = 0;
    while (oe_n !== 1'b0 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (oe_n === 1'b0 && n < 9000) begin
      chk(pin_n === 1'b0 && pin_out === 1'b0 && ir === 1'b1, "pin not low in delay");
      n++;
      @(negedge ref_clk);
    end
    chk(n >= r.dmin && n <= r.dmax, "delay length");
    n = 0;
    while (vf === 1'b0 && ir === 1'b1 && n < 5000) begin
      wdog = r.poke && (n == 100);
      n++;
      @(negedge ref_clk);
    end
    chk(n == 4096, "stabilisation length");
    chk(vf === 1'b1 && addr === 16'hfffe, "first fetch");
    @(negedge ref_clk);
    chk(vf === 1'b1 && addr === 16'hffff, "second fetch");
    @(negedge ref_clk);
    chk(vf === 1'b0 && ir === 1'b0 && osc === 1'b1, "release after fetch");
    chk(cause === r.cause, "reset cause");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    rise_ok = 1'b0;
    fall_ok = 1'b0;
    wdog = 1'b0;
    pull_low = 1'b0;
    rows[0] = '{0, reset_sequencer_pkg::CAUSE_WATCHDOG, 25, 25, 1'b0};
    rows[1] = '{1, reset_sequencer_pkg::CAUSE_EXTERNAL, 25, 25, 1'b0};
    rows[2] = '{2, reset_sequencer_pkg::CAUSE_VOLTAGE_DROP, 24, 28, 1'b0};
    rows[3] = '{0, reset_sequencer_pkg::CAUSE_WATCHDOG, 25, 25, 1'b1};
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk(cause === reset_sequencer_pkg::CAUSE_POWER_ON && oe_n === 1'b0 && osc === 1'b1, "power-up state");
    fall_ok = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk(oe_n === 1'b0, "left reset on falling threshold");
    rise_ok = 1'b1;
    measure('{3, reset_sequencer_pkg::CAUSE_POWER_ON, 24, 29, 1'b0});
    chk(nolvd_ir === 1'b0, "absent detector still holds reset");
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      measure(rows[i]);
      $display("test %0d done", i);
    end
    // A pin held low across clock edges starts a sequence at the next edge.
    pull_low = 1'b1;
    repeat (2) @(negedge ref_clk);
    pull_low = 1'b0;
    measure('{3, reset_sequencer_pkg::CAUSE_EXTERNAL, 24, 24, 1'b0});
    $display("test held pin done");
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(cause === reset_sequencer_pkg::CAUSE_POWER_ON && oe_n === 1'b0 && ir === 1'b1, "mid-run reset");
    chk(vf === 1'b0 && addr === 16'hfffe && osc === 1'b1, "mid-run reset outputs");
    srst = 1'b0;
    measure('{3, reset_sequencer_pkg::CAUSE_POWER_ON, 24, 29, 1'b0});
    $display("test mid-run reset done");
    close_out();
  end

  initial begin
    #4000000;
    chk(1'b0, "run timed out");
    close_out();
  end
endmodule
`default_nettype wire
